// file: core/asc_coder.sv
// Alarm coder with presignal and positive acknowledge sequence control
`timescale 1ns/10ps
`include "asc_consts.svh"
module asc_coder import asc_pkg::*; #(
  parameter int TICK_CYC = `ASC_TICK_CYC,
  parameter int TYPE_W = 8,
  parameter int ADDR_W = 10,
  parameter int GZ_N = 99,
  parameter int LZ_N = 20,
  parameter int DW = 9,
  parameter int TW = 10
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic alarmEvt,
  input wire logic alarmCause,
  input wire logic [TYPE_W-1:0] devType,
  input wire logic [ADDR_W-1:0] devAddr,
  input wire logic generalZone,
  input wire logic [GZ_N:1] genZone,
  input wire logic [LZ_N:1] logicZone,
  input wire logic inhibitAny,
  input wire asc_code_e codeSel,
  input wire logic presigEn,
  input wire logic pasEn,
  input wire logic [7:0] presigSec,
  input wire logic keyAckPin,
  input wire logic keySilencePin,
  input wire logic keyResetPin,
  input wire logic keyDrillPin,
  output logic codedOut,
  output logic stage2Out,
  output logic evacOut,
  output logic alarmLed,
  output logic sounder,
  output asc_screen_e screen,
  output logic [TYPE_W-1:0] dispType,
  output logic [ADDR_W-1:0] dispAddr
);
  localparam int PW = $clog2(TICK_CYC + 1);

  logic [PW-1:0] pre_ff, nxt_pre;
  logic tick_ff, nxt_tick, march_ff, nxt_march, ledPh_ff, nxt_ledPh;
  logic [3:0] kS1_ff, kS2_ff, kS3_ff, kSt_ff, kPr_ff, nxt_kSt, nxt_kPr;
  logic ackPress, silencePress, resetPress, drillPress, clearAll, zoneEvt, isTwo;
  logic [7:0] secs;
  logic [DW-1:0] dlyLoad, dly_ff, nxt_dly;
  logic [TW-1:0] twoLoad, two_ff, nxt_two;
  asc_state_e state_ff, nxt_state;
  asc_screen_e scr_ff, nxt_scr;
  logic latch_ff, nxt_latch, ack_ff, nxt_ack, manual_ff, nxt_manual, alt_ff, nxt_alt;
  logic [2:0] dcnt_ff, nxt_dcnt;
  logic evacOut_ff, nxt_evac, led_ff, nxt_led, snd_ff, nxt_snd;
  logic [TYPE_W-1:0] dType_ff, nxt_type;
  logic [ADDR_W-1:0] dAddr_ff, nxt_addr;
  logic run_ff, nxt_run, stg_ff, nxt_stg, tack_ff, nxt_tack;
  logic codedOut_w, screen_ff_is_man;

  assign ackPress = kPr_ff[`ASC_K_ACK];
  assign silencePress = kPr_ff[`ASC_K_SIL];
  assign resetPress = kPr_ff[`ASC_K_RST];
  assign drillPress = kPr_ff[`ASC_K_DRL];
  assign clearAll = resetPress && !alarmCause;
  assign zoneEvt = generalZone || (|genZone) || (|logicZone);
  assign isTwo = codeSel inside {CODE_TWO, CODE_CAN3, CODE_CAN5, CODE_CANMAN};
  assign secs = (presigSec < 8'(`ASC_PRE_MIN_S)) ? 8'(`ASC_PRE_MIN_S) :
                (presigSec > 8'(`ASC_PRE_MAX_S)) ? 8'(`ASC_PRE_MAX_S) : presigSec;
  assign dlyLoad = DW'(int'(secs) * `ASC_MS_PER_S / `ASC_TICK_MS);

  assign codedOut = codedOut_w;
  assign screen_ff_is_man = scr_ff == SCR_MANEVAC;
  assign stage2Out = stg_ff;
  assign evacOut = evacOut_ff;
  assign alarmLed = led_ff;
  assign sounder = snd_ff;
  assign screen = scr_ff;
  assign dispType = dType_ff;
  assign dispAddr = dAddr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Half-second prescaler, LED flash phase and key synchronisers
  always_comb begin
    nxt_tick = pre_ff == PW'(TICK_CYC - 1);
    nxt_pre = nxt_tick ? '0 : PW'(pre_ff + 1'b1);
    nxt_march = nxt_pre < PW'(TICK_CYC / 2);
    nxt_ledPh = tick_ff ? !ledPh_ff : ledPh_ff;
    nxt_kSt = (kS2_ff & kS3_ff) | (kSt_ff & (kS2_ff | kS3_ff));
    nxt_kPr = nxt_kSt & ~kSt_ff;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pre_ff <= '0;
      tick_ff <= 1'b0;
      march_ff <= 1'b0;
      ledPh_ff <= 1'b0;
      kS1_ff <= '0;
      kS2_ff <= '0;
      kS3_ff <= '0;
      kSt_ff <= '0;
      kPr_ff <= '0;
    end else begin
      pre_ff <= nxt_pre;
      tick_ff <= nxt_tick;
      march_ff <= nxt_march;
      ledPh_ff <= nxt_ledPh;
      kS1_ff <= {keyDrillPin, keyResetPin, keySilencePin, keyAckPin};
      kS2_ff <= kS1_ff;
      kS3_ff <= kS2_ff;
      kSt_ff <= nxt_kSt;
      kPr_ff <= nxt_kPr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Presignal and acknowledge sequence state machine with panel outputs
  always_comb begin
    nxt_state = state_ff;
    nxt_dly = dly_ff;
    nxt_latch = latch_ff;
    nxt_ack = ack_ff;
    nxt_manual = manual_ff;
    nxt_alt = alt_ff;
    nxt_dcnt = dcnt_ff;
    nxt_type = dType_ff;
    nxt_addr = dAddr_ff;
    if (tick_ff && dly_ff != '0) begin
      nxt_dly = DW'(dly_ff - 1'b1);
    end
    case (state_ff)
      ST_IDLE: begin
        if (alarmEvt) begin
          nxt_latch = 1'b1;
          nxt_type = devType;
          nxt_addr = devAddr;
          if (inhibitAny) begin
            nxt_state = ST_HOLD;
          end else if (presigEn && pasEn) begin
            nxt_state = ST_PAS;
            nxt_dly = DW'(`ASC_PAS_T);
          end else if (presigEn) begin
            nxt_state = ST_DELAY;
            nxt_dly = dlyLoad;
          end else begin
            nxt_state = ST_EVAC;
          end
        end
      end
      ST_PAS, ST_DELAY: begin
        if (resetPress) begin
          nxt_state = alarmCause ? ST_HOLD : ST_IDLE;
        end else if (alarmEvt && inhibitAny) begin
          nxt_state = ST_HOLD;
        end else if (drillPress) begin
          nxt_state = ST_EVAC;
          nxt_manual = 1'b1;
          nxt_ack = 1'b1;
          nxt_alt = 1'b1;
          nxt_dcnt = '0;
        end else if (alarmEvt) begin
          nxt_state = ST_EVAC;
        end else if (ackPress) begin
          nxt_ack = 1'b1;
          if (state_ff == ST_PAS) begin
            nxt_state = ST_DELAY;
            nxt_dly = dlyLoad;
          end
        end else if (dly_ff == '0) begin
          nxt_state = ST_EVAC;
        end
      end
      ST_EVAC, ST_HOLD: begin
        if (clearAll) begin
          nxt_state = ST_IDLE;
        end else if (ackPress && !manual_ff) begin
          nxt_ack = 1'b1;
        end else if (manual_ff && tick_ff) begin
          if (dcnt_ff == 3'(`ASC_SCR_T - 1)) begin
            nxt_dcnt = '0;
            nxt_alt = !alt_ff;
          end else begin
            nxt_dcnt = 3'(dcnt_ff + 1'b1);
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (nxt_state == ST_IDLE) begin
      nxt_latch = 1'b0;
      nxt_ack = 1'b0;
      nxt_manual = 1'b0;
      nxt_alt = 1'b0;
      nxt_dcnt = '0;
      nxt_dly = '0;
    end
    nxt_evac = nxt_state == ST_EVAC;
    nxt_led = nxt_latch && (nxt_ack || ledPh_ff);
    nxt_snd = nxt_latch && (nxt_manual ? ledPh_ff : !nxt_ack);
    if (!nxt_latch) begin
      nxt_scr = SCR_NORMAL;
    end else if (nxt_manual && nxt_alt) begin
      nxt_scr = SCR_MANEVAC;
    end else begin
      nxt_scr = SCR_ALARM;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      dly_ff <= '0;
      latch_ff <= 1'b0;
      ack_ff <= 1'b0;
      manual_ff <= 1'b0;
      alt_ff <= 1'b0;
      dcnt_ff <= '0;
      dType_ff <= '0;
      dAddr_ff <= '0;
      evacOut_ff <= 1'b0;
      led_ff <= 1'b0;
      snd_ff <= 1'b0;
      scr_ff <= SCR_NORMAL;
    end else begin
      state_ff <= nxt_state;
      dly_ff <= nxt_dly;
      latch_ff <= nxt_latch;
      ack_ff <= nxt_ack;
      manual_ff <= nxt_manual;
      alt_ff <= nxt_alt;
      dcnt_ff <= nxt_dcnt;
      dType_ff <= nxt_type;
      dAddr_ff <= nxt_addr;
      evacOut_ff <= nxt_evac;
      led_ff <= nxt_led;
      snd_ff <= nxt_snd;
      scr_ff <= nxt_scr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Coding run, two-stage timer and second stage flag
  always_comb begin
    case (codeSel)
      CODE_CAN3: twoLoad = TW'(`ASC_MIN_T(`ASC_CAN3_MIN));
      CODE_CAN5: twoLoad = TW'(`ASC_MIN_T(`ASC_CAN5_MIN));
      CODE_TWO: twoLoad = TW'(`ASC_MIN_T(`ASC_TWO_MIN));
      default: twoLoad = '0;
    endcase
    nxt_run = run_ff;
    nxt_stg = stg_ff;
    nxt_two = two_ff;
    nxt_tack = tack_ff;
    if (clearAll) begin
      nxt_run = 1'b0;
      nxt_stg = 1'b0;
      nxt_two = '0;
      nxt_tack = 1'b0;
    end else begin
      if (silencePress) begin
        nxt_run = 1'b0;
      end else if (alarmEvt && codeSel != CODE_NONE) begin
        nxt_run = 1'b1;
        if (!latch_ff) begin
          nxt_two = twoLoad;
          nxt_tack = 1'b0;
        end
      end
      if (codeSel != CODE_TWO) begin
        nxt_tack = 1'b0;
      end else if (ackPress) begin
        nxt_tack = 1'b1;
      end
      if (tick_ff && two_ff != '0 && !tack_ff) begin
        nxt_two = TW'(two_ff - 1'b1);
        if (two_ff == TW'(1) && isTwo) begin
          nxt_stg = 1'b1;
        end
      end
      if (isTwo && run_ff && (drillPress || zoneEvt)) begin
        nxt_stg = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      run_ff <= 1'b0;
      stg_ff <= 1'b0;
      two_ff <= '0;
      tack_ff <= 1'b0;
    end else begin
      run_ff <= nxt_run;
      stg_ff <= nxt_stg;
      two_ff <= nxt_two;
      tack_ff <= nxt_tack;
    end
  end

  asc_pattern #(.CW(5)) uPattern (
    .mclk(mclk),
    .rstn(rstn),
    .tick(tick_ff),
    .marchPh(march_ff),
    .run(run_ff),
    .stage2(stg_ff),
    .mode(codeSel),
    .patOut(codedOut_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Behaviour checks
  property p_second;
    @(posedge mclk) disable iff (!rstn)
    (state_ff == ST_DELAY && alarmEvt && !inhibitAny && !resetPress && !drillPress)
      |=> evacOut_ff && state_ff == ST_EVAC;
  endproperty
  a_second: assert property (p_second) else $error("second alarm missed");

  property p_inhibit;
    @(posedge mclk) disable iff (!rstn)
    (state_ff inside {ST_PAS, ST_DELAY} && alarmEvt && inhibitAny && !resetPress)
      |=> !evacOut_ff && state_ff == ST_HOLD;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit did not abort");

  property p_abort;
    @(posedge mclk) disable iff (!rstn)
    (state_ff == ST_DELAY && resetPress) |=> !evacOut_ff [*2];
  endproperty
  a_abort: assert property (p_abort) else $error("reset key evacuated");

  property p_drill;
    @(posedge mclk) disable iff (!rstn)
    (state_ff == ST_DELAY && drillPress && !resetPress && !(alarmEvt && inhibitAny))
      |=> evacOut_ff && alarmLed && screen_ff_is_man;
  endproperty
  a_drill: assert property (p_drill) else $error("drill did not evacuate");

  property p_ack;
    @(posedge mclk) disable iff (!rstn)
    (state_ff == ST_DELAY && ackPress && !resetPress && !drillPress && !alarmEvt)
      |=> !snd_ff && led_ff && !evacOut_ff;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge not honoured");

  property p_expire;
    @(posedge mclk) disable iff (!rstn)
    (state_ff inside {ST_PAS, ST_DELAY} && dly_ff == '0 && !resetPress && !drillPress
      && !alarmEvt && !ackPress) |=> evacOut_ff;
  endproperty
  a_expire: assert property (p_expire) else $error("delay expiry ignored");

  property p_pasOpen;
    @(posedge mclk) disable iff (!rstn)
    (state_ff == ST_IDLE && alarmEvt && presigEn && pasEn && !inhibitAny)
      |=> state_ff == ST_PAS && dly_ff == DW'(`ASC_PAS_T) && !evacOut_ff;
  endproperty
  a_pasOpen: assert property (p_pasOpen) else $error("window not opened");

  property p_silence;
    @(posedge mclk) disable iff (!rstn)
    silencePress |=> !run_ff ##1 !codedOut_w;
  endproperty
  a_silence: assert property (p_silence) else $error("silence ignored");

  property p_clear;
    @(posedge mclk) disable iff (!rstn)
    (clearAll && !alarmEvt) |=> state_ff == ST_IDLE && !evacOut_ff && !led_ff && !run_ff;
  endproperty
  a_clear: assert property (p_clear) else $error("reset key left state");

  property p_canAck;
    @(posedge mclk) disable iff (!rstn)
    (codeSel == CODE_CAN3 && ackPress && two_ff > TW'(1) && !clearAll)
      |=> two_ff != '0 && !tack_ff;
  endproperty
  a_canAck: assert property (p_canAck) else $error("ack stopped timer");

  property p_zone;
    @(posedge mclk) disable iff (!rstn)
    (isTwo && run_ff && zoneEvt && !clearAll) |=> stg_ff;
  endproperty
  a_zone: assert property (p_zone) else $error("zone event missed");
endmodule

// file: core/asc_consts.svh
// Timing, index and pattern constants of the alarm signal coder
// Behaviour
// - California code: coded output on 10 s, off 5 s, repeating.
// - Temporal code: three 0.5 s pulses, 0.5 s gaps, last gap 1.5 s.
// - Three-minute Canadian: 20 per minute alert; temporal on drill, zone or expiry.
// - Five-minute Canadian: as three-minute, but the timer runs five minutes.
// - Qualifying zone event: general alarm zone, general zones 1-99, logic 1-20.
// - In Canadian modes acknowledge never stops the stage timer.
// - Manual Canadian: no timer; temporal only on drill or zone event.
// - Alarm with a code selected latches and pulses the coded output.
// - Signal silence turns the pulsing coded output off.
// - Presignal holds evacuation outputs off for a 60-180 s delay.
// - Positive acknowledge sequence: 15 s to acknowledge, else evacuate at once.
// - Alarm with a sequence inhibit input aborts delay with evacuation off; an evacuation already on stays on.
// - A second alarm during the delay evacuates immediately.
// - Presignal alarm flashes LED, sounds sounder, latches until clear plus reset.
// - Acknowledge during delay silences sounder and makes the LED steady.
// - System reset during delay aborts without evacuating.
// - Drill during delay evacuates, pulses sounder, LED steady, manual screen.
// - Manual evacuation alternates manual and alarm screens every 3 s.
// - Delay expiry without operator action evacuates.
// - Initiating device type and loop address go to the display.
// - March time pulses at 120 per minute; temporal is the default pattern decode.
// - Basic two-stage: 20 per minute alert, temporal if unacknowledged 5 min.
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH

`define ASC_CLK_MHZ 250
`define ASC_MS_PER_S 1000
`define ASC_TICK_MS 500
`define ASC_TICK_CYC (`ASC_TICK_MS * 1000 * `ASC_CLK_MHZ)

`define ASC_CAL_ON_S 10
`define ASC_CAL_OFF_S 5
`define ASC_CAL_ON_T (`ASC_CAL_ON_S * `ASC_MS_PER_S / `ASC_TICK_MS)
`define ASC_CAL_PER_T ((`ASC_CAL_ON_S + `ASC_CAL_OFF_S) * `ASC_MS_PER_S / `ASC_TICK_MS)
`define ASC_TMP_ON_MS 500
`define ASC_TMP_LONG_MS 1500
`define ASC_TMP_PULSES 3
`define ASC_TMP_ON_T (`ASC_TMP_ON_MS / `ASC_TICK_MS)
`define ASC_TMP_LIT_T ((2 * `ASC_TMP_PULSES - 1) * `ASC_TMP_ON_T)
`define ASC_TMP_PER_T ((5 * `ASC_TMP_ON_MS + `ASC_TMP_LONG_MS) / `ASC_TICK_MS)
`define ASC_ALERT_PPM 20
`define ASC_ALERT_PER_T (60 * `ASC_MS_PER_S / `ASC_ALERT_PPM / `ASC_TICK_MS)
`define ASC_MARCH_PPM 120

`define ASC_CAN3_MIN 3
`define ASC_CAN5_MIN 5
`define ASC_TWO_MIN 5
`define ASC_MIN_T(m) ((m) * 60 * `ASC_MS_PER_S / `ASC_TICK_MS)
`define ASC_PAS_S 15
`define ASC_PAS_T (`ASC_PAS_S * `ASC_MS_PER_S / `ASC_TICK_MS)
`define ASC_PRE_MIN_S 60
`define ASC_PRE_MAX_S 180
`define ASC_SCR_S 3
`define ASC_SCR_T (`ASC_SCR_S * `ASC_MS_PER_S / `ASC_TICK_MS)

`define ASC_K_ACK 0
`define ASC_K_SIL 1
`define ASC_K_RST 2
`define ASC_K_DRL 3

`endif

// file: core/asc_pattern.sv
// Coded output pulse pattern generator
`timescale 1ns/10ps
`include "asc_consts.svh"
module asc_pattern import asc_pkg::*; #(
  parameter int CW = 5
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic marchPh,
  input wire logic run,
  input wire logic stage2,
  input wire asc_code_e mode,
  output logic patOut
);
  logic [CW-1:0] cnt_ff, nxt_cnt, per, tmpIdx;
  logic stg_ff, out_ff, nxt_out, on, tmpOn;

  assign patOut = out_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Phase counter in ticks and pattern decode
  always_comb begin
    tmpIdx = CW'(cnt_ff / CW'(`ASC_TMP_ON_T));
    tmpOn = (cnt_ff < CW'(`ASC_TMP_LIT_T)) && !tmpIdx[0];
    per = CW'(`ASC_TMP_PER_T);
    on = tmpOn;
    case (mode)
      CODE_MARCH: begin
        per = CW'(1);
        on = marchPh;
      end
      CODE_CALIF: begin
        per = CW'(`ASC_CAL_PER_T);
        on = cnt_ff < CW'(`ASC_CAL_ON_T);
      end
      CODE_TWO, CODE_CAN3, CODE_CAN5, CODE_CANMAN: begin
        if (!stage2) begin
          per = CW'(`ASC_ALERT_PER_T);
          on = cnt_ff < CW'(`ASC_ALERT_PER_T / 2);
        end
      end
      default: begin
        per = CW'(`ASC_TMP_PER_T);
      end
    endcase
    nxt_cnt = cnt_ff;
    if (!run || stage2 != stg_ff) begin
      nxt_cnt = '0;
    end else if (tick) begin
      nxt_cnt = (cnt_ff >= CW'(per - 1'b1)) ? '0 : CW'(cnt_ff + 1'b1);
    end
    nxt_out = run && on && mode != CODE_NONE;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_ff <= '0;
      stg_ff <= 1'b0;
      out_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      stg_ff <= stage2;
      out_ff <= nxt_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pattern checks
  property p_calOn;
    @(posedge mclk) disable iff (!rstn)
    (run && mode == CODE_CALIF && stage2 == stg_ff && cnt_ff < CW'(`ASC_CAL_ON_T)) |=> out_ff;
  endproperty
  a_calOn: assert property (p_calOn) else $error("california on phase lost");

  property p_tmpLong;
    @(posedge mclk) disable iff (!rstn)
    (run && mode == CODE_TEMPORAL && cnt_ff >= CW'(`ASC_TMP_LIT_T)) |=> !out_ff;
  endproperty
  a_tmpLong: assert property (p_tmpLong) else $error("temporal long gap driven");

  property p_march;
    @(posedge mclk) disable iff (!rstn)
    (run && mode == CODE_MARCH) |=> out_ff == $past(marchPh);
  endproperty
  a_march: assert property (p_march) else $error("march time phase wrong");
endmodule

// file: core/asc_pkg.sv
// Types shared by the alarm signal coder modules
package asc_pkg;
  typedef enum logic [2:0] {CODE_NONE, CODE_MARCH, CODE_CALIF, CODE_TEMPORAL, CODE_TWO,
                            CODE_CAN3, CODE_CAN5, CODE_CANMAN} asc_code_e;
  typedef enum logic [2:0] {ST_IDLE, ST_PAS, ST_DELAY, ST_EVAC, ST_HOLD} asc_state_e;
  typedef enum logic [1:0] {SCR_NORMAL, SCR_ALARM, SCR_MANEVAC} asc_screen_e;
endpackage

// file: verif/asc_keypad.sv
// Operator keypad model for the alarm signal coder
`timescale 1ns/10ps
module asc_keypad (
  input wire logic mclk,
  input wire logic [3:0] press,
  output logic [3:0] keys
);
  int hold [4] = '{0, 0, 0, 0};
  // A request holds its key down 8 cycles, long enough to register once
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      if (press[i]) hold[i] <= 8;
      else if (hold[i] > 0) hold[i] <= hold[i] - 1;
    end
  end
  // Released keys read low
  always_comb begin
    for (int i = 0; i < 4; i++) keys[i] = (hold[i] != 0);
  end
endmodule

// file: verif/testbench.sv
// Self-checking bench of the alarm signal coder
`timescale 1ns/10ps
`include "asc_consts.svh"
module testbench import asc_pkg::*;;
  localparam int TK = 8;
  logic mclk = 0, rstn = 0, evt = 0, cause = 0, gz = 0, inh = 0, pen = 0, positive_ack_sequence = 0;
  logic [99:1] zn = '0;
  logic [20:1] lz = '0;
  logic [7:0] ty = 8'hA5, sec = 8'h3C, oTy;
  logic [9:0] ad = 10'h2C3, oAd;
  logic [3:0] press = 4'h0, keys;
  asc_code_e code = CODE_NONE;
  asc_screen_e scr;
  logic coded, st2, evac, led, snd;
  int fail_count = 0, checked = 0;

  asc_coder #(.TICK_CYC(TK)) u_asc_coder (.mclk(mclk), .rstn(rstn), .alarmEvt(evt),
    .alarmCause(cause), .devType(ty), .devAddr(ad), .generalZone(gz), .genZone(zn),
    .logicZone(lz), .inhibitAny(inh), .codeSel(code), .presigEn(pen), .pasEn(positive_ack_sequence),
    .presigSec(sec), .keyAckPin(keys[`ASC_K_ACK]), .keySilencePin(keys[`ASC_K_SIL]),
    .keyResetPin(keys[`ASC_K_RST]), .keyDrillPin(keys[`ASC_K_DRL]), .codedOut(coded),
    .stage2Out(st2), .evacOut(evac), .alarmLed(led), .sounder(snd), .screen(scr),
    .dispType(oTy), .dispAddr(oAd));
  asc_keypad u_asc_keypad (.mclk(mclk), .press(press), .keys(keys));

  // 250 MHz clock
  always #2 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////////
  // Compare one output bit
  task automatic chk(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t bit %b exp %b", $time, g, e);
    end
  endtask
  // Compare a field or a count
  task automatic chkv(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t value %0h exp %0h", $time, g, e);
    end
  endtask
  // Wait n edges, then step off the edge
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Press one key and let it register
  task automatic key(input int k);
    press[k] = 1'h1;
    wt(1);
    press[k] = 1'h0;
    wt(12);
  endtask
  // One alarm event with the cause present
  task automatic alarm();
    cause = 1'h1;
    evt = 1'h1;
    wt(1);
    evt = 1'h0;
    wt(1);
  endtask
  // Reset key with the cause gone clears everything
  task automatic clr();
    cause = 1'h0;
    key(`ASC_K_RST);
    chk(evac | coded | st2 | led | snd, 1'h0);
    pen = 1'h0;
    positive_ack_sequence = 1'h0;
  endtask
  // Count cycles with the coded output, or the manual screen, up
  task automatic cnt(input bit scrSel, input int n, output int c);
    c = 0;
    repeat (n) begin
      wt(1);
      c += scrSel ? int'(scr == SCR_MANEVAC) : int'(coded === 1'h1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Duty of march, California, temporal and basic two-stage over one period (eight for march), then silence
  task automatic t_codes();
    asc_code_e m [4] = '{CODE_MARCH, CODE_CALIF, CODE_TEMPORAL, CODE_TWO};
    int per [4] = '{8 * TK, 30 * TK, 8 * TK, 6 * TK};
    int on [4] = '{4 * TK, 20 * TK, 3 * TK, 3 * TK};
    int c;
    for (int i = 0; i < 4; i++) begin
      code = m[i];
      alarm();
      wt(20);
      cnt(0, per[i], c);
      chkv(c, on[i]);
      key(`ASC_K_SIL);
      wt(20);
      chk(coded, 1'h0);
      clr();
    end
  endtask
  // Stage timer expiry; acknowledge stops only the basic timer
  task automatic t_stage(input asc_code_e m, input int tk, input bit ack, input logic e);
    code = m;
    alarm();
    if (ack) key(`ASC_K_ACK);
    wt(tk * TK - 24 - (ack ? 13 : 0));
    chk(st2, 1'h0);
    wt(48);
    chk(st2, e);
    clr();
  endtask
  // Manual two-stage waits for a zone event of each kind
  task automatic t_zone();
    for (int z = 0; z < 3; z++) begin
      code = CODE_CANMAN;
      alarm();
      wt(z == 0 ? 3000 : 2);
      chk(st2, 1'h0);
      gz = (z == 0);
      zn[99] = (z == 1);
      lz[20] = (z == 2);
      wt(3);
      chk(st2, 1'h1);
      {gz, zn[99], lz[20]} = 3'h0;
      clr();
    end
  endtask
  // Presignal delay with no action, one operator key, a second alarm or an inhibit alarm
  task automatic t_pre(input int act);
    int c;
    pen = 1'h1;
    positive_ack_sequence = (act == 5);
    alarm();
    chk(snd, 1'h1);
    chk(evac, 1'h0);
    chkv(scr, SCR_ALARM);
    chkv({oTy, oAd}, {8'hA5, 10'h2C3});
    case (act)
      1: begin
        key(`ASC_K_ACK);
        chk(snd, 1'h0);
        for (int i = 0; i < 9; i++) begin
          chk(led, 1'h1);
          wt(3);
        end
        key(`ASC_K_RST);
        wt(1000);
        chk(evac, 1'h0);
      end
      2: begin
        key(`ASC_K_DRL);
        chk(evac & led, 1'h1);
        cnt(1, 12 * TK, c);
        chkv(c, 6 * TK);
      end
      3: begin
        alarm();
        chk(evac, 1'h1);
      end
      4: begin
        inh = 1'h1;
        alarm();
        inh = 1'h0;
        wt(1000);
        chk(evac, 1'h0);
      end
      default: begin
        wt((act == 5 ? 30 : 120) * TK - 40);
        chk(evac, 1'h0);
        wt(60);
        chk(evac, 1'h1);
      end
    endcase
    clr();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Print the counts and the verdict, then stop
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Reset, then the scenarios
  initial begin
    wt(10);
    rstn = 1'h1;
    wt(1);
    chk(evac | coded | st2 | led | snd, 1'h0);
    chkv(scr, SCR_NORMAL);
    t_codes();
    t_stage(CODE_CAN3, 360, 1'h1, 1'h1);
    t_stage(CODE_CAN5, 600, 1'h0, 1'h1);
    t_stage(CODE_TWO, 600, 1'h1, 1'h0);
    t_zone();
    for (int a = 0; a < 6; a++) t_pre(a);
    summarize();
  end
  // Cuts a hang short at about three times the expected run
  initial begin
    wt(60000);
    fail_count++;
    summarize();
  end
endmodule
